// File: hw/ssmc_defs.svh
// ssmc_defs.svh: constants of the supply supervisor mode control block
// assumes a 100 MHz clock; included by bare name from hw/
`ifndef SSMC_DEFS_SVH
`define SSMC_DEFS_SVH

`define SSMC_CLK_MHZ          100
`define SSMC_SETTLE_FAST_NS   2000
`define SSMC_SETTLE_SLOW_NS   150000
`define SSMC_HAZARD_NS        1000
`define SSMC_CNT_W            16
`define SSMC_MODE_W           2
`define SSMC_MODE_OFF         2'h0
`define SSMC_MODE_NORMAL      2'h1
`define SSMC_MODE_FULL        2'h2

`endif

// File: hw/ssmc_pkg.sv
// ssmc_pkg.sv: types shared by the supervisor mode control files
// assumes ssmc_defs.svh is on the include path
package ssmc_pkg;
  // low-power sequencing states
  typedef enum logic [1:0] {
    SSMC_ST_ACTIVE,
    SSMC_ST_ENTRY,
    SSMC_ST_DEEP,
    SSMC_ST_STUCK
  } ssmc_state_e;
endpackage

// File: hw/ssmc_settle_timer.sv
// ssmc_settle_timer.sv: comparator settling delay with a pending flag
// assumes a restart pulse synchronous to clock_in
`timescale 1ns/1ns
`include "ssmc_defs.svh"
module ssmc_settle_timer #(
  parameter int CNT_W = `SSMC_CNT_W
) (
  input  wire logic             clock_in,
  input  wire logic             rstn_in,
  input  wire logic             start_in,
  input  wire logic [CNT_W-1:0] cycles_in,
  output logic                  pending_out,
  output logic                  expire_out
);
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic             pending_r;
  logic             pending_nxt;
  logic             expire_r;
  logic             expire_nxt;

  // restart wins over expiry so a late write always gets a full delay
  always_comb begin
    count_nxt   = count_r;
    pending_nxt = pending_r;
    expire_nxt  = 1'b0;
    if (start_in) begin
      count_nxt   = cycles_in;
      pending_nxt = 1'b1;
    end else if (pending_r) begin
      if (count_r <= CNT_W'(1)) begin
        count_nxt   = '0;
        pending_nxt = 1'b0;
        expire_nxt  = 1'b1;
      end else begin
        count_nxt = count_r - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_r   <= '0;
      pending_r <= 1'b0;
      expire_r  <= 1'b0;
    end else begin
      count_r   <= count_nxt;
      pending_r <= pending_nxt;
      expire_r  <= expire_nxt;
    end
  end

  assign pending_out = pending_r;
  assign expire_out  = expire_r;
endmodule // ssmc_settle_timer

// File: hw/ssmc_supervisor_ctrl.sv
// ssmc_supervisor_ctrl.sv: mode selection, settling delays, wake-up time
// and wake-up lockup hazard of the core and supply voltage supervisors
// assumes all inputs synchronous to clock_in; analog comparators outside
`timescale 1ns/1ns
`include "ssmc_defs.svh"

// Notes on behaviour
// - a full-performance core supervisor settles in about 2 us.
// - a normal-performance core supervisor settles in about 150 us.
// - if the core has not reached the requested level when settling ends, a reset is raised.
// - core supervisor and monitor states follow enable, performance, keep bit and auto control.
// - wake-up is fast when the core supervisor is off or full performance, else slow.
// - supply supervisor and monitor states follow the same table as the core side.
// - low-power entry comes from a software request or automatically after an interrupt routine.
// - a stuck wake-up is cleared by external reset, power cycle or power-up-clear reset.
// - the hazard applies when deep entry happens while a settling delay is pending.
// - the hazard also applies with a fast or off core side and a supply side going normal to off.
module ssmc_supervisor_ctrl
  import ssmc_pkg::*;
#(
  parameter int CNT_W = `SSMC_CNT_W
) (
  input  wire logic                    clock_in,
  input  wire logic                    rstn_in,
  input  wire logic                    core_ctl_write_in,
  input  wire logic                    supply_ctl_write_in,
  input  wire logic                    core_supervisor_enable_in,
  input  wire logic                    core_supervisor_lowpower_keep_in,
  input  wire logic                    core_supervisor_full_perf_in,
  input  wire logic                    core_auto_control_enable_in,
  input  wire logic                    core_monitor_enable_in,
  input  wire logic                    core_monitor_full_perf_in,
  input  wire logic                    supply_supervisor_enable_in,
  input  wire logic                    supply_supervisor_lowpower_keep_in,
  input  wire logic                    supply_supervisor_full_perf_in,
  input  wire logic                    supply_auto_control_enable_in,
  input  wire logic                    supply_monitor_enable_in,
  input  wire logic                    supply_monitor_full_perf_in,
  input  wire logic                    lpm_request_in,
  input  wire logic                    isr_return_lpm_in,
  input  wire logic                    deep_mode_in,
  input  wire logic                    interrupt_in,
  input  wire logic                    core_level_ok_in,
  input  wire logic                    puc_reset_in,
  output logic [`SSMC_MODE_W-1:0]      core_supervisor_mode_out,
  output logic [`SSMC_MODE_W-1:0]      core_monitor_mode_out,
  output logic [`SSMC_MODE_W-1:0]      supply_supervisor_mode_out,
  output logic [`SSMC_MODE_W-1:0]      supply_monitor_mode_out,
  output logic                         core_settle_pending_flag_out,
  output logic                         supply_settle_pending_flag_out,
  output logic                         wakeup_slow_out,
  output logic                         in_low_power_out,
  output logic                         wake_stuck_out,
  output logic                         core_reset_out
);
  // ************************************************************
  // timing constants
  // ************************************************************
  // least times round up to whole cycles
  localparam int FAST_CYC = (`SSMC_SETTLE_FAST_NS * `SSMC_CLK_MHZ + 999) / 1000;
  localparam int SLOW_CYC = (`SSMC_SETTLE_SLOW_NS * `SSMC_CLK_MHZ + 999) / 1000;
  localparam int HAZ_CYC  = (`SSMC_HAZARD_NS * `SSMC_CLK_MHZ + 999) / 1000;

  initial begin
    if (CNT_W < 15 || CNT_W > 31 || SLOW_CYC >= (1 << CNT_W))
      $error("ssmc_supervisor_ctrl: CNT_W too small or too large");
  end

  // ************************************************************
  // mode selection
  // ************************************************************
  // one table serves supervisors and monitors on both sides
  function automatic logic [`SSMC_MODE_W-1:0] active_mode(input logic en, input logic fp);
    if (!en)
      return `SSMC_MODE_OFF;
    return fp ? `SSMC_MODE_FULL : `SSMC_MODE_NORMAL;
  endfunction

  function automatic logic [`SSMC_MODE_W-1:0] deep_mode_of(input logic en, input logic keep,
                                                           input logic fp, input logic ace);
    if (!en)
      return `SSMC_MODE_OFF;
    if (ace)
      return (keep && fp) ? `SSMC_MODE_NORMAL : `SSMC_MODE_OFF;
    return keep ? active_mode(en, fp) : `SSMC_MODE_OFF;
  endfunction

  logic [`SSMC_MODE_W-1:0] cs_act, cs_lpm, cm_act, cm_lpm;
  logic [`SSMC_MODE_W-1:0] ss_act, ss_lpm, sm_act, sm_lpm;

  // monitors have no keep bit; they behave as if it were set
  always_comb begin
    cs_act = active_mode(core_supervisor_enable_in, core_supervisor_full_perf_in);
    cs_lpm = deep_mode_of(core_supervisor_enable_in, core_supervisor_lowpower_keep_in,
                          core_supervisor_full_perf_in, core_auto_control_enable_in);
    cm_act = active_mode(core_monitor_enable_in, core_monitor_full_perf_in);
    cm_lpm = deep_mode_of(core_monitor_enable_in, 1'b1,
                          core_monitor_full_perf_in, core_auto_control_enable_in);
    ss_act = active_mode(supply_supervisor_enable_in, supply_supervisor_full_perf_in);
    ss_lpm = deep_mode_of(supply_supervisor_enable_in, supply_supervisor_lowpower_keep_in,
                          supply_supervisor_full_perf_in, supply_auto_control_enable_in);
    sm_act = active_mode(supply_monitor_enable_in, supply_monitor_full_perf_in);
    sm_lpm = deep_mode_of(supply_monitor_enable_in, 1'b1,
                          supply_monitor_full_perf_in, supply_auto_control_enable_in);
  end

  // ************************************************************
  // settling delays
  // ************************************************************
  logic [CNT_W-1:0] core_cycles;
  logic             core_expire;
  logic             core_pend;
  logic             supply_pend;
  logic             state_is_deep;

  // normal performance gives the long delay that covers a core ramp
  assign core_cycles = core_supervisor_full_perf_in ? CNT_W'(FAST_CYC) : CNT_W'(SLOW_CYC);

  ssmc_settle_timer #(.CNT_W(CNT_W)) u_core_settle (
    .clock_in    (clock_in),
    .rstn_in     (rstn_in),
    .start_in    (core_ctl_write_in),
    .cycles_in   (core_cycles),
    .pending_out (core_pend),
    .expire_out  (core_expire)
  );

  ssmc_settle_timer #(.CNT_W(CNT_W)) u_supply_settle (
    .clock_in    (clock_in),
    .rstn_in     (rstn_in),
    .start_in    (supply_ctl_write_in),
    .cycles_in   (supply_supervisor_full_perf_in ? CNT_W'(FAST_CYC) : CNT_W'(SLOW_CYC)),
    .pending_out (supply_pend),
    .expire_out  ()
  );

  // ************************************************************
  // low-power sequencing and hazard
  // ************************************************************
  ssmc_state_e      state_r, state_nxt;
  logic [CNT_W-1:0] win_r, win_nxt;
  logic             hazard_r, hazard_nxt;
  logic             enter;
  logic             cfg_hazard;
  logic             core_fast;

  assign enter      = (lpm_request_in || isr_return_lpm_in) && deep_mode_in;
  assign core_fast  = (cs_act != `SSMC_MODE_NORMAL) || (cm_act != `SSMC_MODE_NORMAL);
  // supply side dropping from normal to off on deep entry
  assign cfg_hazard = core_fast &&
                      ((ss_act == `SSMC_MODE_NORMAL && ss_lpm == `SSMC_MODE_OFF) ||
                       (sm_act == `SSMC_MODE_NORMAL && sm_lpm == `SSMC_MODE_OFF));
  assign state_is_deep = (state_r == SSMC_ST_ENTRY) || (state_r == SSMC_ST_DEEP);

  // an interrupt inside the entry window of a hazardous entry locks wake-up
  always_comb begin
    state_nxt  = state_r;
    win_nxt    = win_r;
    hazard_nxt = hazard_r;
    case (state_r)
      SSMC_ST_ACTIVE: begin
        if (enter) begin
          state_nxt  = SSMC_ST_ENTRY;
          win_nxt    = CNT_W'(HAZ_CYC);
          hazard_nxt = core_pend || supply_pend || cfg_hazard;
        end
      end
      SSMC_ST_ENTRY: begin
        if (interrupt_in) begin
          state_nxt = hazard_r ? SSMC_ST_STUCK : SSMC_ST_ACTIVE;
        end else if (win_r <= CNT_W'(1)) begin
          state_nxt = SSMC_ST_DEEP;
        end else begin
          win_nxt = win_r - CNT_W'(1);
        end
      end
      SSMC_ST_DEEP: begin
        if (interrupt_in)
          state_nxt = SSMC_ST_ACTIVE;
      end
      SSMC_ST_STUCK: begin
        state_nxt = SSMC_ST_STUCK; // only a reset leaves this state
      end
      default: state_nxt = SSMC_ST_ACTIVE;
    endcase
    // power-up-clear releases a stuck wake-up without a full reset
    if (puc_reset_in) begin
      state_nxt  = SSMC_ST_ACTIVE;
      hazard_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r  <= SSMC_ST_ACTIVE;
      win_r    <= '0;
      hazard_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      win_r    <= win_nxt;
      hazard_r <= hazard_nxt;
    end
  end

  // ************************************************************
  // registered outputs
  // ************************************************************
  logic [`SSMC_MODE_W-1:0] cs_r, cm_r, ss_r, sm_r, cs_nxt, cm_nxt, ss_nxt, sm_nxt;
  logic                    cpend_r, spend_r, slow_r, lp_r, stuck_r, rst_r;
  logic                    slow_nxt, lp_nxt, stuck_nxt, rst_nxt;

  always_comb begin
    cs_nxt    = state_is_deep ? cs_lpm : cs_act;
    cm_nxt    = state_is_deep ? cm_lpm : cm_act;
    ss_nxt    = state_is_deep ? ss_lpm : ss_act;
    sm_nxt    = state_is_deep ? sm_lpm : sm_act;
    slow_nxt  = (cs_act == `SSMC_MODE_NORMAL);
    lp_nxt    = state_is_deep || (state_r == SSMC_ST_STUCK);
    stuck_nxt = (state_r == SSMC_ST_STUCK);
    // core level must be good by the end of the settling delay
    rst_nxt   = core_expire && !core_level_ok_in;
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cs_r    <= `SSMC_MODE_OFF;
      cm_r    <= `SSMC_MODE_OFF;
      ss_r    <= `SSMC_MODE_OFF;
      sm_r    <= `SSMC_MODE_OFF;
      cpend_r <= 1'b0;
      spend_r <= 1'b0;
      slow_r  <= 1'b0;
      lp_r    <= 1'b0;
      stuck_r <= 1'b0;
      rst_r   <= 1'b0;
    end else begin
      cs_r    <= cs_nxt;
      cm_r    <= cm_nxt;
      ss_r    <= ss_nxt;
      sm_r    <= sm_nxt;
      cpend_r <= core_pend;
      spend_r <= supply_pend;
      slow_r  <= slow_nxt;
      lp_r    <= lp_nxt;
      stuck_r <= stuck_nxt;
      rst_r   <= rst_nxt;
    end
  end

  assign core_supervisor_mode_out       = cs_r;
  assign core_monitor_mode_out          = cm_r;
  assign supply_supervisor_mode_out     = ss_r;
  assign supply_monitor_mode_out        = sm_r;
  assign core_settle_pending_flag_out   = cpend_r;
  assign supply_settle_pending_flag_out = spend_r;
  assign wakeup_slow_out                = slow_r;
  assign in_low_power_out               = lp_r;
  assign wake_stuck_out                 = stuck_r;
  assign core_reset_out                 = rst_r;
endmodule // ssmc_supervisor_ctrl

// File: bench/ssmc_checker.sv
// ssmc_checker.sv: concurrent checks on the supervisor mode control ports
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/1ns
`include "ssmc_defs.svh"
module ssmc_checker #(
  parameter int CNT_W = `SSMC_CNT_W
) (
  input wire logic       clock_in,
  input wire logic       rstn_in,
  input wire logic       core_ctl_write_in,
  input wire logic       core_supervisor_enable_in,
  input wire logic       core_supervisor_full_perf_in,
  input wire logic       supply_supervisor_enable_in,
  input wire logic       supply_supervisor_full_perf_in,
  input wire logic       lpm_request_in,
  input wire logic       isr_return_lpm_in,
  input wire logic       deep_mode_in,
  input wire logic       interrupt_in,
  input wire logic       core_level_ok_in,
  input wire logic       puc_reset_in,
  input wire logic [1:0] core_supervisor_mode_out,
  input wire logic [1:0] supply_supervisor_mode_out,
  input wire logic       core_settle_pending_flag_out,
  input wire logic       wakeup_slow_out,
  input wire logic       in_low_power_out,
  input wire logic       wake_stuck_out,
  input wire logic       core_reset_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  // ******************************
  // settling delay and reset
  // ******************************
  core_set_a: assert property (core_ctl_write_in |-> ##2 core_settle_pending_flag_out)
    else $error("pending flag not raised");
  fast_clear_a: assert property (core_ctl_write_in && core_supervisor_full_perf_in |->
    ##150 core_settle_pending_flag_out ##[1:60] !core_settle_pending_flag_out) else $error("fast delay off");
  slow_hold_a: assert property (core_ctl_write_in && !core_supervisor_full_perf_in |->
    ##300 core_settle_pending_flag_out) else $error("slow delay too short");
  reset_cause_a: assert property (core_reset_out |-> !$past(core_level_ok_in) ##1 !core_reset_out)
    else $error("bad core reset");
  // ******************************
  // modes, wake-up and lockup
  // ******************************
  core_off_a: assert property (!$past(core_supervisor_enable_in) |-> core_supervisor_mode_out == `SSMC_MODE_OFF)
    else $error("disabled core not off");
  supply_active_a: assert property ($past(rstn_in, 2) && !in_low_power_out && !$past(in_low_power_out)
    && $past(supply_supervisor_enable_in) |-> supply_supervisor_mode_out ==
    ($past(supply_supervisor_full_perf_in) ? `SSMC_MODE_FULL : `SSMC_MODE_NORMAL)) else $error("supply mode");
  wake_speed_a: assert property ($past(rstn_in, 2) |-> wakeup_slow_out ==
    ($past(core_supervisor_enable_in) && !$past(core_supervisor_full_perf_in))) else $error("wake speed");
  stuck_hold_a: assert property (wake_stuck_out && !puc_reset_in && !$past(puc_reset_in) |=> wake_stuck_out)
    else $error("lockup left early");
  entry_path_a: assert property ((lpm_request_in || isr_return_lpm_in) && deep_mode_in && !in_low_power_out
    && !interrupt_in |-> ##2 in_low_power_out) else $error("no entry");
  cover property ($rose(wake_stuck_out));
  cover property (core_reset_out);
  cover property ($rose(in_low_power_out));
endmodule // ssmc_checker

bind ssmc_supervisor_ctrl ssmc_checker #(.CNT_W(CNT_W)) u_chk (.*);

// File: bench/tb.sv
// tb.sv: directed bench for the supervisor mode control block
// assumes the checker is bound by its own file
`timescale 1ns/1ns
`include "ssmc_defs.svh"
module tb;
  localparam int FAST = `SSMC_SETTLE_FAST_NS * `SSMC_CLK_MHZ / 1000;
  localparam int SLOW = `SSMC_SETTLE_SLOW_NS * `SSMC_CLK_MHZ / 1000;
  localparam int HOLD = `SSMC_HAZARD_NS * `SSMC_CLK_MHZ / 1000;
  logic clock_in, rstn_in, core_ctl_write_in, supply_ctl_write_in, lpm_request_in, isr_return_lpm_in;
  logic deep_mode_in, interrupt_in, core_level_ok_in, puc_reset_in, wakeup_slow_out, in_low_power_out;
  logic core_supervisor_enable_in, core_supervisor_lowpower_keep_in, core_supervisor_full_perf_in;
  logic core_auto_control_enable_in, core_monitor_enable_in, core_monitor_full_perf_in;
  logic supply_supervisor_enable_in, supply_supervisor_lowpower_keep_in, supply_supervisor_full_perf_in;
  logic supply_auto_control_enable_in, supply_monitor_enable_in, supply_monitor_full_perf_in;
  logic [1:0] core_supervisor_mode_out, core_monitor_mode_out, supply_supervisor_mode_out, supply_monitor_mode_out;
  logic core_settle_pending_flag_out, supply_settle_pending_flag_out, wake_stuck_out, core_reset_out;
  logic [5:0] cc, sc;
  int n_fail, comparisons, cyc;

  ssmc_supervisor_ctrl uut (.*);

  // ******************************
  // clock, timeout, helpers
  // ******************************
  initial begin
    clock_in = 0;
    forever #5 clock_in = ~clock_in;
  end
  // the longest run is four settling delays plus the mode sweep
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    tick(1);
    s = 0;
  endtask
  task automatic do_reset();
    rstn_in = 0;
    tick(10);
    rstn_in = 1;
    tick(2);
  endtask
  // config order per side: enable, keep, full perf, auto, monitor enable, monitor full perf
  task automatic set_cfg(input logic [5:0] c, input logic [5:0] s);
    cc = c;
    sc = s;
    {core_supervisor_enable_in, core_supervisor_lowpower_keep_in, core_supervisor_full_perf_in} = c[5:3];
    {core_auto_control_enable_in, core_monitor_enable_in, core_monitor_full_perf_in} = c[2:0];
    {supply_supervisor_enable_in, supply_supervisor_lowpower_keep_in, supply_supervisor_full_perf_in} = s[5:3];
    {supply_auto_control_enable_in, supply_monitor_enable_in, supply_monitor_full_perf_in} = s[2:0];
  endtask
  function automatic logic [1:0] mexp(input logic en, keep, fp, ace, deep);
    if (!en) return `SSMC_MODE_OFF;
    if (!deep) return fp ? `SSMC_MODE_FULL : `SSMC_MODE_NORMAL;
    if (ace) return (keep && fp) ? `SSMC_MODE_NORMAL : `SSMC_MODE_OFF;
    return keep ? (fp ? `SSMC_MODE_FULL : `SSMC_MODE_NORMAL) : `SSMC_MODE_OFF;
  endfunction
  // monitors have no keep bit, so manual control keeps their active state
  task automatic chk_modes(input logic d);
    cmp(core_supervisor_mode_out, mexp(cc[5], cc[4], cc[3], cc[2], d), "core sup");
    cmp(core_monitor_mode_out, mexp(cc[1], 1'b1, cc[0], cc[2], d), "core mon");
    cmp(supply_supervisor_mode_out, mexp(sc[5], sc[4], sc[3], sc[2], d), "sup sup");
    cmp(supply_monitor_mode_out, mexp(sc[1], 1'b1, sc[0], sc[2], d), "sup mon");
  endtask
  // write, then measure how long the pending flag stands and count resets
  task automatic settle(input logic core, input logic fp, input logic ok, input int en, input int er);
    int n, r, w;
    n = 0;
    r = 0;
    w = 0;
    core_level_ok_in = ok;
    if (core) core_supervisor_full_perf_in = fp;
    else supply_supervisor_full_perf_in = fp;
    if (core) pulse(core_ctl_write_in);
    else pulse(supply_ctl_write_in);
    while ((core ? core_settle_pending_flag_out : supply_settle_pending_flag_out) !== 1'b1 && w < 5) begin
      w++;
      tick(1);
    end
    while ((core ? core_settle_pending_flag_out : supply_settle_pending_flag_out) === 1'b1 && n < 20000) begin
      n++;
      r += (core_reset_out === 1'b1);
      tick(1);
    end
    repeat (4) begin
      r += (core_reset_out === 1'b1);
      tick(1);
    end
    cmp(16'(n), 16'(en), "settle length");
    cmp(16'(r), 16'(er), "reset count");
  endtask

  // ******************************
  // main sequence
  // ******************************
  initial begin
    cyc = 0;
    n_fail = 0;
    comparisons = 0;
    {core_ctl_write_in, supply_ctl_write_in, lpm_request_in, isr_return_lpm_in, interrupt_in, puc_reset_in} = 0;
    deep_mode_in = 1;
    core_level_ok_in = 1;
    set_cfg(6'h00, 6'h00);
    do_reset();
    settle(1, 1, 0, FAST, 1);
    settle(1, 0, 1, SLOW, 0);
    settle(0, 1, 0, FAST, 0);
    settle(0, 0, 1, SLOW, 0);
    // sweep all sixteen combinations of each supervisor's four bits in active and deep states; waking from deep is always safe
    for (int i = 0; i < 16; i++) begin
      set_cfg({i[3:0], i[3], i[1]}, {i[3:0] ^ 4'h6, ~i[0], i[2]});
      tick(3);
      chk_modes(0);
      cmp(wakeup_slow_out, cc[5] && !cc[3], "wake speed");
      pulse(lpm_request_in);
      tick(HOLD + 5);
      cmp(in_low_power_out, 1, "deep entry");
      chk_modes(1);
      pulse(interrupt_in);
      tick(4);
      cmp(in_low_power_out, 0, "deep wake");
    end
    // early wake while a delay is pending locks up until power-up clear
    set_cfg(6'h22, 6'h00);
    tick(2);
    pulse(core_ctl_write_in);
    tick(3);
    pulse(isr_return_lpm_in);
    tick(20);
    pulse(interrupt_in);
    tick(4);
    cmp(wake_stuck_out, 1, "pending lockup");
    pulse(interrupt_in);
    tick(4);
    cmp(wake_stuck_out, 1, "lockup holds");
    pulse(puc_reset_in);
    tick(4);
    cmp(wake_stuck_out, 0, "clear by puc");
    do_reset();
    // no entry without a deep mode; a slow core side keeps an early wake safe
    set_cfg(6'h22, 6'h20);
    deep_mode_in = 0;
    pulse(lpm_request_in);
    tick(4);
    cmp(in_low_power_out, 0, "shallow request");
    deep_mode_in = 1;
    pulse(lpm_request_in);
    tick(20);
    pulse(interrupt_in);
    tick(4);
    cmp(wake_stuck_out, 0, "safe early wake");
    cmp(in_low_power_out, 0, "safe wake active");
    // fast core side plus a supply side dropping to off locks up
    set_cfg(6'h2B, 6'h20);
    tick(2);
    pulse(lpm_request_in);
    tick(20);
    pulse(interrupt_in);
    tick(4);
    cmp(wake_stuck_out, 1, "config lockup");
    do_reset();
    cmp(wake_stuck_out, 0, "clear by reset");
    stop_test();
  end
endmodule // tb
